// >>> include/dccr_pkg.sv
// dccr_pkg: constants, offsets and field layout of the core control and capture registers
package dccr_pkg;

  // ************************************************************
  // register locations on the control port
  // ************************************************************
  localparam logic [11:0] ADDR_AUX_CONV_0 = 12'h809;
  localparam logic [11:0] ADDR_AUX_CONV_3 = 12'h80C;
  localparam logic [11:0] ADDR_SL_TARGET_0 = 12'h815;
  localparam logic [11:0] ADDR_SL_TARGET_4 = 12'h819;
  localparam logic [11:0] ADDR_CAPTURE_0 = 12'h81A;
  localparam logic [11:0] ADDR_CAPTURE_1 = 12'h81B;
  localparam logic [11:0] ADDR_CORE_CONTROL = 12'h81C;

  // ************************************************************
  // counts and widths
  // ************************************************************
  localparam int SL_SLOTS = 5;
  localparam int AUX_CHANNELS = 4;
  localparam int CAP_CHANNELS = 2;
  localparam int CORE_WORD_W = 28;
  localparam int CAPTURE_W = 24;
  localparam int CAPTURE_DROP = 4;
  localparam logic [15:0] RESET_WORD = 16'h0000;

  // ************************************************************
  // capture setup word fields
  // ************************************************************
  localparam int CAP_STEP_LSB = 2;
  localparam int CAP_STEP_MSB = 11;
  localparam int CAP_SRC_LSB = 0;
  localparam int CAP_SRC_MSB = 1;

  // ************************************************************
  // core control word fields
  // ************************************************************
  localparam int CTL_RATE_LSB = 0;
  localparam int CTL_RATE_MSB = 1;
  localparam int CTL_CLEAR_N = 2;
  localparam int CTL_OUT_MUTE_N = 3;
  localparam int CTL_IN_MUTE_N = 4;
  localparam int CTL_SL_TRIGGER = 5;
  localparam int CTL_IFACE_WE = 6;
  localparam int CTL_PIN_WE = 7;
  localparam int CTL_AUX_WE = 8;
  localparam int CTL_DEB_LSB = 12;
  localparam int CTL_DEB_MSB = 13;
  localparam logic [15:0] CTL_WRITE_MASK = 16'h31FF;

  // ************************************************************
  // debounce intervals, in milliseconds and in clk_sys cycles
  // ************************************************************
  localparam int CLK_SYS_KHZ = 125000;
  localparam int DEB_TIME_00_MS = 20;
  localparam int DEB_TIME_01_MS = 40;
  localparam int DEB_TIME_10_MS = 10;
  localparam int DEB_TIME_11_MS = 5;
  localparam int DEB_CYCLES_00 = DEB_TIME_00_MS * CLK_SYS_KHZ;
  localparam int DEB_CYCLES_01 = DEB_TIME_01_MS * CLK_SYS_KHZ;
  localparam int DEB_CYCLES_10 = DEB_TIME_10_MS * CLK_SYS_KHZ;
  localparam int DEB_CYCLES_11 = DEB_TIME_11_MS * CLK_SYS_KHZ;
  localparam int DEB_PERIOD_W = 23;

  // capture source codes
  typedef enum logic [1:0] {
    DCCR_SRC_MULT_X = 2'b00,
    DCCR_SRC_MULT_Y = 2'b01,
    DCCR_SRC_MAC = 2'b10,
    DCCR_SRC_ACC_FB = 2'b11
  } dccr_src_e;

  // instruction-rate codes
  typedef enum logic [1:0] {
    DCCR_RATE_512 = 2'b00,
    DCCR_RATE_256 = 2'b01,
    DCCR_RATE_128 = 2'b10
  } dccr_rate_e;

  // safeload sequencer states
  typedef enum logic [1:0] {
    DCCR_SL_IDLE = 2'b00,
    DCCR_SL_WAIT = 2'b01,
    DCCR_SL_XFER = 2'b10
  } dccr_sl_state_e;

endpackage : dccr_pkg

// >>> verilog/dccr_capture_chan.sv
// dccr_capture_chan: one data capture channel with its setup word and captured value
`timescale 1ns/10ps
module dccr_capture_chan
  import dccr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic setup_wr,
  input wire logic [11:0] setup_wdata,
  input wire logic step_valid,
  input wire logic [9:0] core_pc,
  input wire logic [CORE_WORD_W-1:0] mult_x_in,
  input wire logic [CORE_WORD_W-1:0] mult_y_in,
  input wire logic [CORE_WORD_W-1:0] multiply_accumulate_result,
  input wire logic [CORE_WORD_W-1:0] accum_feedback,
  output logic [11:0] setup,
  output logic [CAPTURE_W-1:0] captured
);

  logic [9:0] capture_step_index;
  logic [1:0] capture_source_select;
  logic [CORE_WORD_W-1:0] next_word;

  assign capture_step_index = setup[CAP_STEP_MSB:CAP_STEP_LSB];
  assign capture_source_select = setup[CAP_SRC_MSB:CAP_SRC_LSB];

  // setup word keeps step index and source select; nothing above bit 11 exists
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      setup <= RESET_WORD[11:0];
    end else if (ce && setup_wr) begin
      setup <= setup_wdata;
    end
  end

  always_comb begin
    next_word = mult_x_in;
    unique case (dccr_src_e'(capture_source_select))
      DCCR_SRC_MULT_X: next_word = mult_x_in;
      DCCR_SRC_MULT_Y: next_word = mult_y_in;
      DCCR_SRC_MAC: next_word = multiply_accumulate_result;
      DCCR_SRC_ACC_FB: next_word = accum_feedback;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      captured <= '0;
    end else if (ce && step_valid && core_pc == capture_step_index) begin
      captured <= next_word[CORE_WORD_W-1:CAPTURE_DROP];
    end
  end

endmodule : dccr_capture_chan

// >>> verilog/dccr_regs.sv
// dccr_regs: safeload address, data capture and core control register bank
// Notes on behaviour
// - five safeload targets hold 12 bits, upper four read zero, reset zero
// - two independent capture channels latch a chosen program point for readout
// - capture happens when the program counter equals the step index
// - captured value is the 5.23 word with four lsbs dropped
// - setup word: step index in bits 11:2, source select in 1:0
// - source 00 mult x, 01 mult y, 10 mac result, 11 accumulator feedback
// - captured values are read at locations 2074 and 2075
// - debounce field bits 13:12 pick 20, 40, 10 or 5 ms
// - aux converter host writes are accepted only while bit 8 is set
// - with bit 8 set aux registers ignore pin samples and keep host values
// - trigger moves only pairs written since last transfer, then clears itself
// - triggered transfer completes within one audio frame
// - mute and clear bits are active low and reset to zero
// - rate field: 00 512, 01 256, 10 128 instructions per sample
`timescale 1ns/10ps
module dccr_regs
  import dccr_pkg::*;
#(
  parameter int DEB_PERIOD_00 = DEB_CYCLES_00,
  parameter int DEB_PERIOD_01 = DEB_CYCLES_01,
  parameter int DEB_PERIOD_10 = DEB_CYCLES_10,
  parameter int DEB_PERIOD_11 = DEB_CYCLES_11
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // control port side
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  output logic [CAPTURE_W-1:0] reg_rdata,
  output logic reg_rvalid,
  // writes into the safeload data registers, one strobe per pair
  input wire logic [SL_SLOTS-1:0] sl_data_written,
  // audio frame and core program
  input wire logic frame_start,
  input wire logic step_valid,
  input wire logic [9:0] core_pc,
  input wire logic [CORE_WORD_W-1:0] mult_x_in,
  input wire logic [CORE_WORD_W-1:0] mult_y_in,
  input wire logic [CORE_WORD_W-1:0] multiply_accumulate_result,
  input wire logic [CORE_WORD_W-1:0] accum_feedback,
  // auxiliary converter samples, taken once per frame while bit 8 is clear
  input wire logic [AUX_CHANNELS*12-1:0] aux_sample,
  output logic [AUX_CHANNELS*12-1:0] aux_conv_data,
  // safeload transfer to parameter memory
  output logic sl_xfer_valid,
  output logic [2:0] sl_xfer_slot,
  output logic [11:0] sl_xfer_addr,
  // control outputs
  output logic [1:0] pin_debounce_select,
  output logic [DEB_PERIOD_W-1:0] debounce_period,
  output logic aux_conv_host_write_enable,
  output logic pin_setting_host_write_enable,
  output logic iface_reg_host_write_enable,
  output logic safeload_trigger,
  output logic input_conv_mute_n,
  output logic output_conv_mute_n,
  output logic core_clear_n,
  output logic [1:0] rate_multiplier_select,
  output logic [10:0] instructions_per_sample
);

  // ************************************************************
  // decode
  // ************************************************************
  function automatic logic in_range(input logic [11:0] a, input logic [11:0] lo,
                                    input logic [11:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  logic [15:0] core_control;
  logic [11:0] sl_target [SL_SLOTS];
  logic [SL_SLOTS-1:0] sl_pending;
  logic [SL_SLOTS-1:0] sl_target_wr;
  logic [SL_SLOTS-1:0] next_pending;
  logic [CAP_CHANNELS-1:0] cap_setup_wr;
  logic [CAPTURE_W-1:0] cap_value [CAP_CHANNELS];
  logic [AUX_CHANNELS-1:0] aux_wr;
  logic ctl_wr;
  logic sl_done;
  logic [2:0] sl_scan;
  dccr_sl_state_e sl_state;
  logic [CAPTURE_W-1:0] next_rdata;

  assign ctl_wr = reg_wr && reg_addr == ADDR_CORE_CONTROL;

  // one write strobe per addressed word
  always_comb begin
    for (int i = 0; i < SL_SLOTS; i++) begin
      sl_target_wr[i] = reg_wr && reg_addr == ADDR_SL_TARGET_0 + 12'(i);
    end
    for (int i = 0; i < CAP_CHANNELS; i++) begin
      cap_setup_wr[i] = reg_wr && reg_addr == ADDR_CAPTURE_0 + 12'(i);
    end
    for (int i = 0; i < AUX_CHANNELS; i++) begin
      aux_wr[i] = reg_wr && reg_addr == ADDR_AUX_CONV_0 + 12'(i) && core_control[CTL_AUX_WE];
    end
  end

  // ************************************************************
  // safeload targets and pending marks
  // ************************************************************
  // 12-bit targets
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < SL_SLOTS; i++) begin
        sl_target[i] <= RESET_WORD[11:0];
      end
    end else if (ce) begin
      for (int i = 0; i < SL_SLOTS; i++) begin
        if (sl_target_wr[i]) begin
          sl_target[i] <= reg_wdata[11:0];
        end
      end
    end
  end

  // pending marks: a new write wins over the clear of a slot being sent
  always_comb begin
    next_pending = sl_pending;
    if (sl_state == DCCR_SL_XFER) begin
      next_pending[sl_scan] = 1'b0;
    end
    next_pending = next_pending | sl_target_wr | sl_data_written;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sl_pending <= '0;
    end else if (ce) begin
      sl_pending <= next_pending;
    end
  end

  // ************************************************************
  // safeload sequencer
  // ************************************************************
  // waits for a frame edge so the core sees the whole set at once
  assign sl_done = sl_state == DCCR_SL_XFER && sl_scan == 3'(SL_SLOTS - 1);

  // scan five slots right after the next frame edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sl_state <= DCCR_SL_IDLE;
      sl_scan <= 3'h0;
    end else if (ce) begin
      unique case (sl_state)
        DCCR_SL_IDLE: begin
          sl_scan <= 3'h0;
          if (ctl_wr && reg_wdata[CTL_SL_TRIGGER]) begin
            sl_state <= DCCR_SL_WAIT;
          end
        end
        DCCR_SL_WAIT: begin
          if (frame_start) begin
            sl_state <= DCCR_SL_XFER;
          end
        end
        DCCR_SL_XFER: begin
          if (sl_done) begin
            sl_state <= DCCR_SL_IDLE;
          end else begin
            sl_scan <= sl_scan + 3'h1;
          end
        end
        default: begin
          sl_state <= DCCR_SL_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sl_xfer_valid <= 1'b0;
      sl_xfer_slot <= 3'h0;
      sl_xfer_addr <= 12'h000;
    end else if (ce) begin
      sl_xfer_valid <= sl_state == DCCR_SL_XFER && sl_pending[sl_scan];
      sl_xfer_slot <= sl_scan;
      sl_xfer_addr <= sl_target[sl_scan];
    end
  end

  // ************************************************************
  // core control register
  // ************************************************************
  // clears and mutes start at zero, so audio stays blocked
  // trigger drops by itself when the scan ends
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      core_control <= RESET_WORD;
    end else if (ce) begin
      if (ctl_wr) begin
        core_control <= reg_wdata & CTL_WRITE_MASK;
        // a busy trigger cannot be withdrawn by software
        if (sl_state != DCCR_SL_IDLE) begin
          core_control[CTL_SL_TRIGGER] <= ~sl_done;
        end
      end else if (sl_done) begin
        core_control[CTL_SL_TRIGGER] <= 1'b0;
      end
    end
  end

  // control fields straight from the register flops
  assign pin_debounce_select = core_control[CTL_DEB_MSB:CTL_DEB_LSB];
  assign aux_conv_host_write_enable = core_control[CTL_AUX_WE];
  assign pin_setting_host_write_enable = core_control[CTL_PIN_WE];
  assign iface_reg_host_write_enable = core_control[CTL_IFACE_WE];
  assign safeload_trigger = core_control[CTL_SL_TRIGGER];
  assign input_conv_mute_n = core_control[CTL_IN_MUTE_N];
  assign output_conv_mute_n = core_control[CTL_OUT_MUTE_N];
  assign core_clear_n = core_control[CTL_CLEAR_N];
  assign rate_multiplier_select = core_control[CTL_RATE_MSB:CTL_RATE_LSB];

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      debounce_period <= DEB_PERIOD_W'(DEB_PERIOD_00);
    end else if (ce) begin
      unique case (core_control[CTL_DEB_MSB:CTL_DEB_LSB])
        2'b00: debounce_period <= DEB_PERIOD_W'(DEB_PERIOD_00);
        2'b01: debounce_period <= DEB_PERIOD_W'(DEB_PERIOD_01);
        2'b10: debounce_period <= DEB_PERIOD_W'(DEB_PERIOD_10);
        2'b11: debounce_period <= DEB_PERIOD_W'(DEB_PERIOD_11);
      endcase
    end
  end

  // program length per sample; code 11 is unused and held at 512
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      instructions_per_sample <= 11'h200;
    end else if (ce) begin
      unique case (core_control[CTL_RATE_MSB:CTL_RATE_LSB])
        DCCR_RATE_512: instructions_per_sample <= 11'h200;
        DCCR_RATE_256: instructions_per_sample <= 11'h100;
        DCCR_RATE_128: instructions_per_sample <= 11'h080;
        default: instructions_per_sample <= 11'h200;
      endcase
    end
  end

  // ************************************************************
  // auxiliary converter data
  // ************************************************************
  // pin samples taken per frame only while host mode is off
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aux_conv_data <= '0;
    end else if (ce) begin
      for (int i = 0; i < AUX_CHANNELS; i++) begin
        if (core_control[CTL_AUX_WE]) begin
          if (aux_wr[i]) begin
            aux_conv_data[i*12 +: 12] <= reg_wdata[11:0];
          end
        end else if (frame_start) begin
          aux_conv_data[i*12 +: 12] <= aux_sample[i*12 +: 12];
        end
      end
    end
  end

  // ************************************************************
  // data capture channels
  // ************************************************************
  // two independent channels
  for (genvar g = 0; g < CAP_CHANNELS; g++) begin : g_cap
    dccr_capture_chan u_chan (
      .clk_sys(clk_sys),
      .rst(rst),
      .ce(ce),
      .setup_wr(cap_setup_wr[g]),
      .setup_wdata(reg_wdata[11:0]),
      .step_valid(step_valid),
      .core_pc(core_pc),
      .mult_x_in(mult_x_in),
      .mult_y_in(mult_y_in),
      .multiply_accumulate_result(multiply_accumulate_result),
      .accum_feedback(accum_feedback),
      .setup(),
      .captured(cap_value[g])
    );
  end

  // ************************************************************
  // read path
  // ************************************************************
  // one registered answer per read strobe; unmapped reads return zero
  always_comb begin
    next_rdata = '0;
    if (in_range(reg_addr, ADDR_SL_TARGET_0, ADDR_SL_TARGET_4)) begin
      next_rdata = CAPTURE_W'(sl_target[3'(reg_addr - ADDR_SL_TARGET_0)]);
    end else if (in_range(reg_addr, ADDR_AUX_CONV_0, ADDR_AUX_CONV_3)) begin
      next_rdata = CAPTURE_W'(aux_conv_data[2'(reg_addr - ADDR_AUX_CONV_0)*12 +: 12]);
    end else if (reg_addr == ADDR_CAPTURE_0 || reg_addr == ADDR_CAPTURE_1) begin
      next_rdata = cap_value[reg_addr == ADDR_CAPTURE_1];
    end else if (reg_addr == ADDR_CORE_CONTROL) begin
      next_rdata = CAPTURE_W'(core_control);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= '0;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

endmodule : dccr_regs

// >>> verif/dccr_regs_sva.sv
// checker for the core control and capture register bank
`timescale 1ns/10ps
module dccr_regs_chk
  import dccr_pkg::*;
#(
  parameter int DEB_PERIOD_00 = 20,
  parameter int DEB_PERIOD_01 = 40,
  parameter int DEB_PERIOD_10 = 10,
  parameter int DEB_PERIOD_11 = 5
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [11:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [CAPTURE_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic frame_start,
  input wire logic [AUX_CHANNELS*12-1:0] aux_conv_data,
  input wire logic sl_xfer_valid,
  input wire logic [1:0] pin_debounce_select,
  input wire logic [DEB_PERIOD_W-1:0] debounce_period,
  input wire logic aux_conv_host_write_enable,
  input wire logic safeload_trigger,
  input wire logic input_conv_mute_n,
  input wire logic output_conv_mute_n,
  input wire logic core_clear_n,
  input wire logic [1:0] rate_multiplier_select,
  input wire logic [10:0] instructions_per_sample
);
  // ************************************************************
  // expected field maps and sequences
  // ************************************************************
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  // code 11 is undocumented, so only the three defined codes are judged
  function automatic logic [10:0] ips_of(input logic [1:0] r);
    return (r == 2'h1) ? 11'h100 : (r == 2'h2) ? 11'h080 : 11'h200;
  endfunction : ips_of

  function automatic int deb_of(input logic [1:0] g);
    return (g == 2'h0) ? DEB_PERIOD_00 : (g == 2'h1) ? DEB_PERIOD_01 :
      (g == 2'h2) ? DEB_PERIOD_10 : DEB_PERIOD_11;
  endfunction : deb_of

  // trigger armed for at least a cycle, then the frame edge arrives
  sequence s_armed;
    safeload_trigger ##1 safeload_trigger && frame_start && ce;
  endsequence

  a_rd_answer: assert property (ce && reg_rd |=> reg_rvalid)
    else $error("read strobe not answered in the next cycle");
  a_rvalid_pulse: assert property (ce && !reg_rd |=> !reg_rvalid)
    else $error("read valid without a read strobe");
  a_ctl_levels: assert property (ce && reg_wr && reg_addr == ADDR_CORE_CONTROL |=>
    {input_conv_mute_n, output_conv_mute_n, core_clear_n} == $past(reg_wdata[4:2]))
    else $error("mute or clear level differs from written word");
  a_ips_map: assert property (ce && rate_multiplier_select != 2'h3 |=>
    instructions_per_sample == ips_of($past(rate_multiplier_select)))
    else $error("instruction count does not follow rate code");
  a_deb_map: assert property (ce |=>
    debounce_period == deb_of($past(pin_debounce_select)))
    else $error("debounce period does not follow select field");
  a_ctl_reserved: assert property (reg_rvalid && $past(reg_rd) &&
    $past(reg_addr) == ADDR_CORE_CONTROL |-> (reg_rdata & 24'hFFCE00) == 24'h000000)
    else $error("reserved control bits read nonzero");
  a_sl_upper_zero: assert property (reg_rvalid && $past(reg_rd) &&
    $past(reg_addr) inside {[ADDR_SL_TARGET_0:ADDR_SL_TARGET_4]} |-> reg_rdata[23:12] == 12'h000)
    else $error("safeload target upper bits nonzero");
  a_trig_clear: assert property (s_armed |-> safeload_trigger [*6] ##1 !safeload_trigger)
    else $error("trigger not cleared six cycles after frame edge");
  a_xfer_in_run: assert property (sl_xfer_valid |-> $past(safeload_trigger))
    else $error("transfer outside a triggered run");
  a_aux_kept: assert property (aux_conv_host_write_enable && !(reg_wr &&
    reg_addr inside {[ADDR_AUX_CONV_0:ADDR_AUX_CONV_3]}) |=> $stable(aux_conv_data))
    else $error("aux data changed while host owns it");
endmodule : dccr_regs_chk

bind dccr_regs dccr_regs_chk #(.DEB_PERIOD_00(DEB_PERIOD_00), .DEB_PERIOD_01(DEB_PERIOD_01),
  .DEB_PERIOD_10(DEB_PERIOD_10), .DEB_PERIOD_11(DEB_PERIOD_11)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .frame_start(frame_start), .aux_conv_data(aux_conv_data), .sl_xfer_valid(sl_xfer_valid),
  .pin_debounce_select(pin_debounce_select), .debounce_period(debounce_period),
  .aux_conv_host_write_enable(aux_conv_host_write_enable),
  .safeload_trigger(safeload_trigger), .input_conv_mute_n(input_conv_mute_n),
  .output_conv_mute_n(output_conv_mute_n), .core_clear_n(core_clear_n),
  .rate_multiplier_select(rate_multiplier_select),
  .instructions_per_sample(instructions_per_sample));

// >>> verif/test_dccr_regs.sv
// self-checking bench for the core control and capture register bank
`timescale 1ns/10ps
module test_dccr_regs
  import dccr_pkg::*;
;
  logic clk_sys, rst, ce, reg_wr, reg_rd, reg_rvalid, frame_start, step_valid;
  logic [11:0] reg_addr, sl_xfer_addr;
  logic [15:0] reg_wdata, ctl;
  logic [CAPTURE_W-1:0] reg_rdata, capv [2];
  logic [4:0] sl_data_written;
  logic [9:0] core_pc, step;
  logic [CORE_WORD_W-1:0] src [4];
  logic [31:0] cur [4];
  logic [47:0] aux_sample, aux_conv_data, v, a1;
  logic [2:0] sl_xfer_slot;
  logic [1:0] deb_sel, rate_sel;
  logic [DEB_PERIOD_W-1:0] deb_period;
  logic [10:0] ips;
  logic sl_xfer_valid, aux_we, pin_we, if_we, trig, in_mute_n, out_mute_n, clear_n;
  logic [11:0] tgt [5];
  int errors, checks;

  // small debounce counts keep the run short
  dccr_regs #(.DEB_PERIOD_00(20), .DEB_PERIOD_01(40), .DEB_PERIOD_10(10),
    .DEB_PERIOD_11(5)) dut (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .sl_data_written(sl_data_written), .frame_start(frame_start), .step_valid(step_valid),
    .core_pc(core_pc), .mult_x_in(src[0]), .mult_y_in(src[1]),
    .multiply_accumulate_result(src[2]), .accum_feedback(src[3]),
    .aux_sample(aux_sample), .aux_conv_data(aux_conv_data), .sl_xfer_valid(sl_xfer_valid),
    .sl_xfer_slot(sl_xfer_slot), .sl_xfer_addr(sl_xfer_addr), .pin_debounce_select(deb_sel),
    .debounce_period(deb_period), .aux_conv_host_write_enable(aux_we),
    .pin_setting_host_write_enable(pin_we), .iface_reg_host_write_enable(if_we),
    .safeload_trigger(trig), .input_conv_mute_n(in_mute_n), .output_conv_mute_n(out_mute_n),
    .core_clear_n(clear_n), .rate_multiplier_select(rate_sel), .instructions_per_sample(ips));

  // 125 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ************************************************************
  // expectations and bus tasks
  // ************************************************************
  function automatic logic [47:0] exp_ips(input logic [1:0] r);
    return (r == 2'h1) ? 48'h100 : (r == 2'h2) ? 48'h080 : 48'h200;
  endfunction : exp_ips

  function automatic logic [47:0] exp_deb(input logic [1:0] g);
    return (g == 2'h0) ? 48'h14 : (g == 2'h1) ? 48'h28 : (g == 2'h2) ? 48'h0A : 48'h05;
  endfunction : exp_deb

  task chk(input logic [47:0] seen, input logic [47:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input logic [11:0] a, output logic [47:0] q);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rvalid, 1'b1);
    q = {24'h0, reg_rdata};
  endtask : rd

  task frame(input logic [47:0] a);
    @(posedge clk_sys);
    aux_sample <= a;
    frame_start <= 1'b1;
    @(posedge clk_sys);
    frame_start <= 1'b0;
    #1;
  endtask : frame

  task rnd_src;
    for (int j = 0; j < 4; j++) begin
      cur[j] = $urandom;
      src[j] <= cur[j][CORE_WORD_W-1:0];
    end
  endtask : rnd_src

  // fire a transfer and match each slot sent against the pending mask
  task sl_run(input logic [4:0] mask);
    int n;
    int s;
    n = 0;
    s = 0;
    wr(ADDR_CORE_CONTROL, ctl | 16'h0020);
    repeat (3) @(posedge clk_sys);
    frame(aux_sample);
    repeat (10) begin
      @(posedge clk_sys);
      #1;
      if (sl_xfer_valid === 1'b1) begin
        while (s < 4 && !mask[s]) s++;
        chk(sl_xfer_slot, s);
        chk(sl_xfer_addr, tgt[s]);
        s++;
        n++;
      end
    end
    chk(n, $countones(mask));
    chk(trig, 1'b0);
  endtask : sl_run

  task test_done;
    $display("checks=%0d errors=%0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : test_done

  // watchdog: whole sequence needs well under two thousand cycles
  initial begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    test_done;
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    void'($urandom(32'hDE6B));
    {rst, ce, reg_wr, reg_rd, frame_start, step_valid} = 6'b110000;
    {reg_addr, reg_wdata, sl_data_written, core_pc, ctl} = '0;
    aux_sample = '0;
    for (int j = 0; j < 4; j++) src[j] = '0;
    capv[0] = '0;
    capv[1] = '0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    chk(ips, 48'h200);
    chk({in_mute_n, out_mute_n, clear_n}, 3'h0);
    // safeload, capture and control locations read zero after reset, one past the bank included
    for (int a = 12'h815; a <= 12'h81D; a++) begin
      rd(a[11:0], v);
      chk(v, 48'h0);
    end
    for (int i = 0; i < 5; i++) begin
      v = 48'($urandom);
      tgt[i] = v[11:0];
      wr(ADDR_SL_TARGET_0 + i[11:0], v[15:0]);
      rd(ADDR_SL_TARGET_0 + i[11:0], v);
      chk(v, {36'h0, tgt[i]});
    end
    // each debounce and rate code, unused rate 11 too, reserved bits written as ones
    for (int g = 0; g < 4; g++) begin
      ctl = 16'($urandom) & 16'h31DF;
      ctl[13:12] = g[1:0];
      ctl[1:0] = g[1:0];
      wr(ADDR_CORE_CONTROL, ctl | 16'hCE00);
      rd(ADDR_CORE_CONTROL, v);
      chk(v, {32'h0, ctl});
      chk(ips, exp_ips(ctl[1:0]));
      chk(deb_period, exp_deb(ctl[13:12]));
      chk({deb_sel, rate_sel}, {ctl[13:12], ctl[1:0]});
      chk({in_mute_n, out_mute_n, clear_n, aux_we, pin_we, if_we}, {ctl[4:2], ctl[8:6]});
    end
    sl_run(5'h1F);
    tgt[1] = 12'hFFF;
    tgt[3] = 12'h000;
    wr(12'h816, 16'hFFFF);
    wr(12'h818, 16'h0000);
    @(posedge clk_sys);
    sl_data_written <= 5'h10;
    @(posedge clk_sys);
    sl_data_written <= 5'h00;
    sl_run(5'h1A);
    // four captures, every source, step boundaries, channels alternating
    for (int k = 0; k < 4; k++) begin
      step = 10'((k == 0) ? 10'h3FF : (k == 1) ? $urandom_range(499, 2) :
        (k == 2) ? $urandom_range(1000, 502) : 10'h000);
      wr(ADDR_CAPTURE_0 + k[0], {4'h0, step, k[1:0]});
      @(posedge clk_sys);
      step_valid <= 1'b1;
      core_pc <= step ^ 10'h001;
      rnd_src;
      @(posedge clk_sys);
      core_pc <= step;
      rnd_src;
      capv[k % 2] = cur[k][27:4];
      @(posedge clk_sys);
      step_valid <= 1'b0;
      rnd_src;
      rd(ADDR_CAPTURE_0 + k[0], v);
      chk(v, capv[k % 2]);
      rd(ADDR_CAPTURE_1 - k[0], v);
      chk(v, capv[1 - k % 2]);
    end
    // host ownership of the aux converter registers
    ctl[8] = 1'b0;
    wr(ADDR_CORE_CONTROL, ctl);
    a1 = 48'({$urandom, $urandom});
    frame(a1);
    @(posedge clk_sys);
    chk(aux_conv_data, a1);
    wr(12'h80A, 16'h0ABC);
    #1;
    chk(aux_conv_data, a1);
    ctl[8] = 1'b1;
    wr(ADDR_CORE_CONTROL, ctl);
    wr(12'h80A, 16'h0ABC);
    #1;
    chk(aux_conv_data, {a1[47:24], 12'hABC, a1[11:0]});
    frame(~a1);
    @(posedge clk_sys);
    chk(aux_conv_data, {a1[47:24], 12'hABC, a1[11:0]});
    test_done;
  end
endmodule : test_dccr_regs
